// file: sfdp_params.svh
`ifndef SFDP_PARAMS_SVH
`define SFDP_PARAMS_SVH

// ----------------------------------------
// serial protocol
// ----------------------------------------
`define SFDP_CMD_READ     8'h5a
`define SFDP_CMD_BITS     5'd8
`define SFDP_ADDR_BITS    5'd24
`define SFDP_DUMMY_BITS   5'd8
`define SFDP_FILL_BYTE    8'hff

// ----------------------------------------
// header pointer locations and values
// ----------------------------------------
`define OFF_BASIC_PTR     8'h0c
`define OFF_VENDOR_PTR    8'h14
`define BASIC_PTR_WORD    32'hff000030
`define VENDOR_PTR_WORD   32'hff000090

// ----------------------------------------
// table word offsets
// ----------------------------------------
`define OFF_DUAL_READ     8'h3c
`define OFF_MODE_SUPPORT  8'h40
`define OFF_TWO_READ      8'h44
`define OFF_FOUR_READ     8'h48
`define OFF_ERASE_12      8'h4c
`define OFF_ERASE_34      8'h50
`define OFF_ERASE_TIME    8'h54
`define OFF_PROG_TIME     8'h58
`define OFF_SUSP_TIME     8'h5c
`define OFF_SUSP_OPC      8'h60
`define OFF_POLL_PDOWN    8'h64
`define OFF_QUAD_SEQ      8'h68
`define OFF_RESET_ADDR    8'h6c
`define OFF_SUPPLY        8'h90
`define OFF_VENDOR_FEAT   8'h94
`define OFF_LOCK_FEAT     8'h98

// ----------------------------------------
// stored table words, low byte first
// ----------------------------------------
`define VAL_DUAL_READ     32'hbb423b08
`define VAL_MODE_SUPPORT  32'hfffffffe
`define VAL_TWO_READ      32'hff00ffff
`define VAL_FOUR_READ     32'heb44ffff
`define VAL_ERASE_12      32'h520f200c
`define VAL_ERASE_34      32'hff00d810
`define VAL_ERASE_TIME    32'hfec94a42
`define VAL_PROG_TIME     32'h4c14e782
`define VAL_SUSP_TIME     32'h330660ec
`define VAL_SUSP_OPC      32'h757a757a
`define VAL_POLL_PDOWN    32'h5cd5b304
`define VAL_QUAD_SEQ      32'h00740619
`define VAL_RESET_ADDR    32'h00001008
`define VAL_SUPPLY        32'h16502000
`define VAL_VENDOR_FEAT   32'h6477f99c
`define VAL_LOCK_FEAT     32'hffffebfc

`endif

// file: sfdp_pkg.sv
package sfdp_pkg;
   // serial read sequence phases
   typedef enum logic [2:0] {
      ST_CMD,
      ST_ADDR,
      ST_DUMMY,
      ST_DATA,
      ST_IGNORE
   } phase_type;
endpackage

// file: pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter int         WIDTH     = 1,
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // pins in, synchronised out
   input  wire logic [WIDTH-1:0] pin_in,
   output var  logic [WIDTH-1:0] pin_out
);
   // ----------------------------------------
   // two flops per bit
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic stage1_reg;
         // first stage feeds only the second
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               stage1_reg <= RESET_VAL[i];
               pin_out[i] <= RESET_VAL[i];
            end else begin
               stage1_reg <= pin_in[i];
               pin_out[i] <= stage1_reg;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// file: sfdp_rom.sv
`timescale 1ns/1ns
`default_nettype none
`include "sfdp_params.svh"
module sfdp_rom (
   // byte address in, stored byte out
   input  wire logic [23:0] addr,
   output logic      [7:0]  data
);
   // ----------------------------------------
   // word select and byte pick
   // ----------------------------------------
   wire        in_page = (addr[23:8] == 16'h0000);
   wire [7:0]  word_off = {addr[7:2], 2'b00};
   logic [31:0] word;

   // constant contents, no write path exists [R24]
   always_comb begin
      unique case (word_off)
         `OFF_BASIC_PTR:    word = `BASIC_PTR_WORD;   // [R2]
         `OFF_VENDOR_PTR:   word = `VENDOR_PTR_WORD;  // [R2]
         `OFF_DUAL_READ:    word = `VAL_DUAL_READ;    // [R3] [R4]
         `OFF_MODE_SUPPORT: word = `VAL_MODE_SUPPORT; // [R5] [R6]
         `OFF_TWO_READ:     word = `VAL_TWO_READ;     // [R5]
         `OFF_FOUR_READ:    word = `VAL_FOUR_READ;    // [R6]
         `OFF_ERASE_12:     word = `VAL_ERASE_12;     // [R7] [R8]
         `OFF_ERASE_34:     word = `VAL_ERASE_34;     // [R9]
         `OFF_ERASE_TIME:   word = `VAL_ERASE_TIME;   // [R10]
         `OFF_PROG_TIME:    word = `VAL_PROG_TIME;    // [R11]
         `OFF_SUSP_TIME:    word = `VAL_SUSP_TIME;    // [R12] [R13]
         `OFF_SUSP_OPC:     word = `VAL_SUSP_OPC;     // [R12]
         `OFF_POLL_PDOWN:   word = `VAL_POLL_PDOWN;   // [R14] [R15] [R16]
         `OFF_QUAD_SEQ:     word = `VAL_QUAD_SEQ;     // [R17] [R18] [R19]
         `OFF_RESET_ADDR:   word = `VAL_RESET_ADDR;   // [R20] [R21]
         `OFF_SUPPLY:       word = `VAL_SUPPLY;
         `OFF_VENDOR_FEAT:  word = `VAL_VENDOR_FEAT;  // [R21] [R22]
         `OFF_LOCK_FEAT:    word = `VAL_LOCK_FEAT;    // [R23]
         default:           word = {4{`SFDP_FILL_BYTE}};
      endcase
   end

   // little-endian byte within the word; outside the page reads fill
   assign data = !in_page ? `SFDP_FILL_BYTE : word[{addr[1:0], 3'b000} +: 8];
endmodule
`default_nettype wire

// file: sfdp_parameter_table_rom.sv
`timescale 1ns/1ns
`default_nettype none
`include "sfdp_params.svh"

// Functional notes
// R1: read command 5AH, address, bytes in order
// R2: header pointers give 30H and 90H
// R3: 1-1-2 read: 8 waits, no mode, 3BH
// R4: 1-2-2 read: 2 waits, mode 010b, BBH
// R5: 2-2-2 unsupported, zero fields, opcode FFH
// R6: 4-4-4 supported: 4 waits, 010b, EBH
// R7: erase type 1: 4 KiB, opcode 20H
// R8: erase type 2: 32 KiB, opcode 52H
// R9: type 3 64 KiB D8H; type 4 absent
// R10: erase timing codes and multiplier 0010b
// R11: page size and program time codes
// R12: suspend 75H, resume 7AH, supported
// R13: 64 us interval, 20 us suspend latency
// R14: busy polled via 05h bit 0
// R15: deep power-down supported with opcodes
// R16: power-down exit delay 20 us
// R17: quad mode enable/disable codes 0001b/1001b
// R18: continuous read enter AXH, exit 00H
// R19: quad enable in status 2 bit 1
// R20: status 1 write-enable code 0001000b
// R21: soft reset 66H then 99H
// R22: wrap read 77H, lengths 8 to 64
// R23: block/read lock unsupported, OTP supported
// R24: store is read-only, writes ignored
module sfdp_parameter_table_rom (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // serial pins, asynchronous to clk
   input  wire logic cs_n,
   input  wire logic sclk,
   input  wire logic si_in,
   // serial data out, two signals of io1
   output var  logic so_out,
   output var  logic so_oe,
   // current phase, for observation
   output var  sfdp_pkg::phase_type phase
);
   import sfdp_pkg::*;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] pins_sync;

   // chip select idles high, so it resets high
   pin_sync #(
      .WIDTH     (3),
      .RESET_VAL (8'h04)
   ) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .pin_in  ({cs_n, sclk, si_in}),
      .pin_out (pins_sync)
   );

   wire cs_n_s = pins_sync[2];
   wire sclk_s = pins_sync[1];
   wire si_s   = pins_sync[0];

   // ----------------------------------------
   // serial clock edge detect
   // ----------------------------------------
   logic sclk_prev_reg;

   // edges come from the second stage only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_prev_reg <= 1'b0;
      end else begin
         sclk_prev_reg <= sclk_s;
      end
   end

   wire selected = !cs_n_s;
   wire rise     = selected && sclk_s && !sclk_prev_reg;
   wire fall     = selected && !sclk_s && sclk_prev_reg;

   // ----------------------------------------
   // state and registers
   // ----------------------------------------
   phase_type   phase_reg;
   phase_type   phase_next;
   logic [4:0]  bit_cnt_reg;
   logic [4:0]  bit_cnt_next;
   logic [23:0] shift_in_reg;
   logic [23:0] shift_in_next;
   logic [23:0] addr_reg;
   logic [23:0] addr_next;
   logic [2:0]  out_cnt_reg;
   logic [2:0]  out_cnt_next;
   logic [7:0]  shift_out_reg;
   logic [7:0]  shift_out_next;
   logic        so_reg;
   logic        so_next;
   logic        oe_reg;
   logic        oe_next;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire [23:0] shifted   = {shift_in_reg[22:0], si_s};
   wire [4:0]  cnt_inc   = bit_cnt_reg + 5'd1;
   wire        cmd_done  = (cnt_inc == `SFDP_CMD_BITS);
   wire        addr_done = (cnt_inc == `SFDP_ADDR_BITS);
   wire        dmy_done  = (cnt_inc == `SFDP_DUMMY_BITS);
   wire        cmd_ok    = (shifted[7:0] == `SFDP_CMD_READ);
   wire        byte_load = (out_cnt_reg == 3'd0);
   wire [7:0]  rom_byte;

   // stored table, addressed by the running byte pointer
   sfdp_rom u_rom (
      .addr (addr_reg),
      .data (rom_byte)
   );

   // ----------------------------------------
   // sequence control
   // ----------------------------------------
   // inputs are taken on the rising serial edge
   always_comb begin
      phase_next    = phase_reg;
      bit_cnt_next  = bit_cnt_reg;
      shift_in_next = shift_in_reg;
      addr_next     = addr_reg;
      if (!selected) begin
         // deselect aborts any phase at once
         phase_next   = ST_CMD;
         bit_cnt_next = 5'd0;
      end else if (rise) begin
         unique case (phase_reg)
            ST_CMD: begin
               shift_in_next = shifted;
               bit_cnt_next  = cmd_done ? 5'd0 : cnt_inc;
               if (cmd_done) begin
                  // other opcodes, writes included, are ignored [R1] [R24]
                  phase_next = cmd_ok ? ST_ADDR : ST_IGNORE;
               end
            end
            ST_ADDR: begin
               shift_in_next = shifted;
               bit_cnt_next  = addr_done ? 5'd0 : cnt_inc;
               if (addr_done) begin
                  addr_next  = shifted; // [R1]
                  phase_next = ST_DUMMY;
               end
            end
            ST_DUMMY: begin
               bit_cnt_next = dmy_done ? 5'd0 : cnt_inc;
               if (dmy_done) begin
                  phase_next = ST_DATA;
               end
            end
            ST_DATA: begin
               // host input is don't-care while data flows
               phase_next = ST_DATA;
            end
            ST_IGNORE: begin
               // wait out the frame without storing anything [R24]
               phase_next = ST_IGNORE;
            end
         endcase
      end else if (fall && phase_reg == ST_DATA && byte_load) begin
         // pointer advances as each byte is loaded [R1]
         addr_next = addr_reg + 24'd1;
      end
   end

   // ----------------------------------------
   // output shifter
   // ----------------------------------------
   // data changes on the falling serial edge, msb first
   always_comb begin
      out_cnt_next   = out_cnt_reg;
      shift_out_next = shift_out_reg;
      so_next        = so_reg;
      oe_next        = selected && (phase_reg == ST_DATA);
      if (!selected || phase_reg != ST_DATA) begin
         out_cnt_next = 3'd0;
      end else if (fall) begin
         out_cnt_next = out_cnt_reg + 3'd1;
         if (byte_load) begin
            so_next        = rom_byte[7]; // [R1]
            shift_out_next = {rom_byte[6:0], 1'b0};
         end else begin
            so_next        = shift_out_reg[7];
            shift_out_next = {shift_out_reg[6:0], 1'b0};
         end
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // control state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_reg    <= ST_CMD;
         bit_cnt_reg  <= 5'd0;
         shift_in_reg <= 24'h000000;
         addr_reg     <= 24'h000000;
      end else begin
         phase_reg    <= phase_next;
         bit_cnt_reg  <= bit_cnt_next;
         shift_in_reg <= shift_in_next;
         addr_reg     <= addr_next;
      end
   end

   // output path
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_cnt_reg   <= 3'd0;
         shift_out_reg <= 8'h00;
         so_reg        <= 1'b0;
         oe_reg        <= 1'b0;
      end else begin
         out_cnt_reg   <= out_cnt_next;
         shift_out_reg <= shift_out_next;
         so_reg        <= so_next;
         oe_reg        <= oe_next;
      end
   end

   assign so_out = so_reg;
   assign so_oe  = oe_reg;
   assign phase  = phase_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // a wrong opcode never reaches the address phase
   chk_bad_opcode: assert property ( // [R24]
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ST_CMD && rise && cmd_done && !cmd_ok)
      |=> phase_reg == ST_IGNORE)
      else $error("non-read opcode not ignored");

   // the read opcode opens the address phase
   chk_read_opcode: assert property ( // [R1]
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ST_CMD && rise && cmd_done && cmd_ok)
      |=> phase_reg == ST_ADDR && bit_cnt_reg == 5'd0)
      else $error("read opcode not accepted");

   // address is captured after exactly 24 bits
   chk_addr_capture: assert property ( // [R1]
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ST_ADDR && rise && bit_cnt_reg == 5'd23)
      |=> phase_reg == ST_DUMMY && addr_reg == $past(shifted))
      else $error("address not captured");

   // the first byte goes out after eight dummy clocks
   chk_dummy_len: assert property ( // [R1]
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ST_DUMMY && rise && bit_cnt_reg == 5'd7)
      |=> phase_reg == ST_DATA)
      else $error("dummy length wrong");

   // byte order follows the address
   chk_byte_order: assert property ( // [R1]
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ST_DATA && fall && byte_load && selected)
      |=> addr_reg == $past(addr_reg) + 24'd1
          && so_reg == $past(rom_byte[7]))
      else $error("byte sequence broken");

   // the driver is on only while data flows
   chk_drive_window: assert property ( // [R1]
      @(posedge clk) disable iff (!reset_n)
      so_oe |-> $past(phase_reg == ST_DATA && selected))
      else $error("output enabled outside data");

   // dual-output read word content
   chk_dual_word: assert property ( // [R3]
      @(posedge clk) disable iff (!reset_n)
      (addr_reg == 24'h00003d) |-> rom_byte == 8'h3b)
      else $error("dual read opcode wrong");

   // basic table pointer content
   chk_basic_ptr: assert property ( // [R2]
      @(posedge clk) disable iff (!reset_n)
      (addr_reg == 24'h00000c) |-> rom_byte == 8'h30)
      else $error("basic pointer wrong");

   // vendor table pointer content
   chk_vendor_ptr: assert property ( // [R2]
      @(posedge clk) disable iff (!reset_n)
      (addr_reg == 24'h000014) |-> rom_byte == 8'h90)
      else $error("vendor pointer wrong");

   // ignored frames never drive the pin
   chk_ignore_quiet: assert property ( // [R24]
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ST_IGNORE) [*2] |-> !so_oe)
      else $error("ignored frame drives output");

   // deselect ends any frame on the next edge and frees io1
   chk_cs_abort: assert property ( // [R1]
      @(posedge clk) disable iff (!reset_n)
      !selected |=> phase_reg == ST_CMD && !so_oe)
      else $error("deselect did not abort frame");

   // a refused frame stays refused until deselect
   chk_ignore_sticky: assert property ( // [R24]
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ST_IGNORE && selected) |=> phase_reg == ST_IGNORE)
      else $error("refused frame resumed");

   // the byte pointer moves only at address capture or a byte load
   chk_addr_hold: assert property ( // [R1]
      @(posedge clk) disable iff (!reset_n)
      (phase_reg != ST_DATA && !(phase_reg == ST_ADDR && rise && addr_done))
      |=> $stable(addr_reg))
      else $error("byte pointer moved outside data");

   // every falling edge in data advances the bit count
   chk_bit_count: assert property ( // [R1]
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ST_DATA && fall) |=> out_cnt_reg == $past(out_cnt_reg) + 3'd1)
      else $error("bit count did not advance");

   // bits after the first come from the shifter, msb first
   chk_shift_msb: assert property ( // [R1]
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ST_DATA && fall && !byte_load) |=> so_reg == $past(shift_out_reg[7]))
      else $error("shifted bit out of order");

   // quad read opcode content
   chk_quad_opc: assert property ( // [R6]
      @(posedge clk) disable iff (!reset_n)
      (addr_reg == 24'h00004b) |-> rom_byte == 8'heb)
      else $error("quad read opcode wrong");

   // small sector erase opcode content
   chk_erase_one: assert property ( // [R7]
      @(posedge clk) disable iff (!reset_n)
      (addr_reg == 24'h00004d) |-> rom_byte == 8'h20)
      else $error("sector erase opcode wrong");

   // program suspend opcode content
   chk_susp_opc: assert property ( // [R12]
      @(posedge clk) disable iff (!reset_n)
      (addr_reg == 24'h000061) |-> rom_byte == 8'h75)
      else $error("suspend opcode wrong");

   // wrap read opcode content
   chk_wrap_opc: assert property ( // [R22]
      @(posedge clk) disable iff (!reset_n)
      (addr_reg == 24'h000096) |-> rom_byte == 8'h77)
      else $error("wrap read opcode wrong");
endmodule
`default_nettype wire

// file: spi_host.sv
`timescale 1ns/1ns
`default_nettype none
module spi_host (
   // clock
   input  wire logic clk,
   // serial pins toward the parameter store
   output var  logic cs_n,
   output var  logic sclk,
   output var  logic si_in,
   input  wire logic so_out,
   input  wire logic so_oe
);
   logic last_bit;
   logic io1;

   // io1 has no pull, so a released line shows the inverse of its last level
   assign io1 = so_oe ? so_out : ~last_bit;

   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si_in = 1'b0;
      last_bit = 1'b0;
   end

   // one mode-0 bit: halves of 5 clk keep sclk well inside the sampling limit
   task automatic bit_xfer(input logic b, output logic r);
      @(negedge clk);
      sclk <= 1'b0;
      si_in <= b;
      repeat (5) @(negedge clk);
      r = io1;
      last_bit = io1;
      sclk <= 1'b1;
      repeat (4) @(negedge clk);
   endtask

   // whole frame; stop > 0 deselects after that many bits, mid-byte if wanted
   task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int n,
                        input logic [7:0] wdat, input int stop,
                        output logic [31:0] w, output logic oe_seen);
      logic [39:0] hdr;
      logic [7:0]  b;
      logic        r;
      hdr = {op, addr, 8'h00};
      w = 32'h0;
      b = 8'h0;
      oe_seen = 1'b0;
      @(negedge clk);
      cs_n <= 1'b0;
      repeat (2) @(negedge clk);
      // opcode then address msb first, dummy, then bytes in address order
      for (int i = 0; i < 40 + 8 * n; i++) begin
         if (stop != 0 && i == stop) break;
         bit_xfer(i < 40 ? hdr[39 - i] : wdat[7 - i % 8], r);
         if (i == 40) oe_seen = so_oe;
         b = {b[6:0], r};
         if (i >= 40 && i % 8 == 7) w = {b, w[31:8]};
      end
      @(negedge clk);
      sclk <= 1'b0;
      repeat (5) @(negedge clk);
      cs_n <= 1'b1;
      repeat (6) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// file: sfdp_parameter_table_rom_bench.sv
`timescale 1ns/1ns
`default_nettype none
module sfdp_parameter_table_rom_bench import sfdp_pkg::*;;
   logic       clk;
   logic       reset_n;
   logic       cs_n;
   logic       sclk;
   logic       si_in;
   logic       so_out;
   logic       so_oe;
   phase_type  phase;
   logic [31:0] w;
   logic        oe;
   int          num_errors;
   int          total_checks;

   sfdp_parameter_table_rom i_sfdp_parameter_table_rom (
      .clk     (clk),
      .reset_n (reset_n),
      .cs_n    (cs_n),
      .sclk    (sclk),
      .si_in   (si_in),
      .so_out  (so_out),
      .so_oe   (so_oe),
      .phase   (phase)
   );

   spi_host i_spi_host (
      .clk    (clk),
      .cs_n   (cs_n),
      .sclk   (sclk),
      .si_in  (si_in),
      .so_out (so_out),
      .so_oe  (so_oe)
   );

   // ----------------------------------------
   // clock, compare and closing helpers
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // deselected store must release io1 and return to the command phase
   task automatic idle_chk;
      check("so_oe idle", 32'h0, {31'h0, so_oe});
      check("phase idle", {29'h0, ST_CMD}, {29'h0, phase});
   endtask

   // a word comes back low byte first from four incrementing addresses
   task automatic rd_word(input logic [23:0] a, input logic [31:0] exp);
      i_spi_host.frame(8'h5a, a, 4, 8'h00, 0, w, oe);
      check($sformatf("word %h", a), exp, w);
      check("so_oe data", 32'h1, {31'h0, oe});
      idle_chk();
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      num_errors = 0;
      total_checks = 0;
      reset_n = 1'b0;
      repeat (5) @(negedge clk);
      reset_n <= 1'b1;
      repeat (4) @(negedge clk);
      idle_chk();

      rd_word(24'h00000c, 32'hff000030);
      rd_word(24'h000014, 32'hff000090);
      $display("test header_pointers done");

      rd_word(24'h00003c, 32'hbb423b08);
      rd_word(24'h000040, 32'hfffffffe);
      rd_word(24'h000044, 32'hff00ffff);
      rd_word(24'h000048, 32'heb44ffff);
      rd_word(24'h00004c, 32'h520f200c);
      rd_word(24'h000050, 32'hff00d810);
      rd_word(24'h000054, 32'hfec94a42);
      rd_word(24'h000058, 32'h4c14e782);
      rd_word(24'h00005c, 32'h330660ec);
      rd_word(24'h000060, 32'h757a757a);
      rd_word(24'h000064, 32'h5cd5b304);
      rd_word(24'h000068, 32'h00740619);
      rd_word(24'h00006c, 32'h00001008);
      rd_word(24'h000090, 32'h16502000);
      rd_word(24'h000094, 32'h6477f99c);
      rd_word(24'h000098, 32'hffffebfc);
      $display("test table_words done");

      // burst runs past the table end into unlisted space
      rd_word(24'h00006e, 32'hffff0000);
      rd_word(24'h000100, 32'hffffffff);
      $display("test increment_edges done");

      // a foreign opcode gets no answer at all
      i_spi_host.frame(8'h03, 24'h00003c, 2, 8'h00, 0, w, oe);
      check("so_oe refused", 32'h0, {31'h0, oe});
      idle_chk();
      // a program attempt carrying zero data must leave the word untouched
      i_spi_host.frame(8'h02, 24'h00003c, 4, 8'h00, 0, w, oe);
      check("so_oe program", 32'h0, {31'h0, oe});
      idle_chk();
      rd_word(24'h00003c, 32'hbb423b08);
      $display("test refused_and_program done");

      // deselect in the address, then mid-byte in the data phase
      i_spi_host.frame(8'h5a, 24'h00003c, 1, 8'h00, 20, w, oe);
      idle_chk();
      i_spi_host.frame(8'h5a, 24'h000040, 1, 8'h00, 44, w, oe);
      idle_chk();
      rd_word(24'h000040, 32'hfffffffe);
      $display("test abort_frames done");

      wrap_up();
   end

   // hang guard: the whole run needs far less than this
   initial begin
      #800us;
      num_errors++;
      $display("[ERR] run time expected below limit seen limit reached");
      wrap_up();
   end
endmodule
`default_nettype wire
